// ### rtl/slpec_consts.svh
/*
 * Constants for the static low-power entry controller: sync field
 * positions, default sizes and reset values.
 * Assumes it is included by bare name from rtl/ files only.
 */
// Contract
// - static state keeps storage, drives safe I/O
// - first variant: freeze pin alone enters
// - second variant: wait for qualifying signal
// - power loss drops memory, I/O, register state (code only clears ctx_valid and stream state; pads and fsm kept)
// - controller reloads state; device restores it
`ifndef SLPEC_CONSTS_SVH
`define SLPEC_CONSTS_SVH

`define SLPEC_SYNC_W        2
`define SLPEC_SYNC_FREEZE   0
`define SLPEC_SYNC_QUAL     1

`define SLPEC_DATA_W_DEF    8
`define SLPEC_DEPTH_DEF     16
`define SLPEC_IO_W_DEF      8

`define SLPEC_SAFE_OUT_DEF  8'h00
`define SLPEC_SAFE_OE_DEF   8'h00

`endif

// ### rtl/slpec_ctrl.sv
/*
 * Static low-power entry controller: two entry variants, pad
 * freezing, context memory with save and restore streams.
 * Assumes the context controller and user logic run on core_clk;
 * only the freeze and qualify pins are asynchronous.
 */
`timescale 1ns/1ps
`include "slpec_consts.svh"

module slpec_ctrl
#(
	parameter int                 DATA_W   = `SLPEC_DATA_W_DEF,
	parameter int                 DEPTH    = `SLPEC_DEPTH_DEF,
	parameter int                 IO_W     = `SLPEC_IO_W_DEF,
	parameter logic [IO_W-1:0]    SAFE_OUT = `SLPEC_SAFE_OUT_DEF,
	parameter logic [IO_W-1:0]    SAFE_OE  = `SLPEC_SAFE_OE_DEF
)
(
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      srst,
	// entry control
	input  wire logic                      freeze_request_pin,
	input  wire logic                      qualify_pin,
	input  wire logic                      qualify_int,
	input  wire logic                      entry_type2,
	// status
	output logic                           frozen,
	output logic                           holdoff,
	output slpec_pkg::slpec_fsm_t          state,
	// pads
	input  wire logic [IO_W-1:0]           io_out_in,
	input  wire logic [IO_W-1:0]           io_oe_in,
	output logic [IO_W-1:0]                io_out,
	output logic [IO_W-1:0]                io_oe,
	// user context port
	input  wire logic                      ctx_we,
	input  wire logic [$clog2(DEPTH)-1:0]  ctx_addr,
	input  wire logic [DATA_W-1:0]         ctx_wdata,
	output logic [DATA_W-1:0]              ctx_rdata,
	output logic                           ctx_valid,
	// power
	input  wire logic                      core_pwr_good,
	input  wire logic                      cold_start,
	// save stream to controller
	input  wire logic                      save_start,
	input  wire logic                      save_ready,
	output logic                           save_valid,
	output logic [DATA_W-1:0]              save_data,
	output logic                           save_last,
	// restore stream from controller
	input  wire logic                      restore_start,
	input  wire logic                      restore_valid,
	input  wire logic [DATA_W-1:0]         restore_data,
	output logic                           restore_done
);
	import slpec_pkg::*;

	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DATA_W < 1
			|| IO_W < 1)
		begin : g_bad_param
			$error("slpec_ctrl: DEPTH must be a power of two >= 2");
		end
	endgenerate

	typedef struct packed {
		slpec_fsm_t        fsm;
		slpec_xfer_t       xfer;
		logic [AW-1:0]     cnt;
		logic              ctx_valid;
		logic [IO_W-1:0]   io_out;
		logic [IO_W-1:0]   io_oe;
		logic              frozen;
		logic              holdoff;
		logic [DATA_W-1:0] rdata;
		logic              sv_valid;
		logic [DATA_W-1:0] sv_data;
		logic              sv_last;
		logic              rs_done;
	} slpec_state_t;

	slpec_state_t      st_r;
	slpec_state_t      st_nxt;
	logic [DATA_W-1:0] mem [DEPTH];
	logic              mem_we;
	logic [AW-1:0]     mem_waddr;
	logic [DATA_W-1:0] mem_wdata;
	logic              freeze_s;
	logic              qual_s;
	logic              user_wr_ok;

	slpec_sync_if sync_if ();

	assign sync_if.raw[`SLPEC_SYNC_FREEZE] = freeze_request_pin;
	assign sync_if.raw[`SLPEC_SYNC_QUAL]   = qualify_pin;

	slpec_sync u_sync
	(
		.core_clk (core_clk),
		.srst     (srst),
		.port_if  (sync_if)
	);

	assign freeze_s = sync_if.synced[`SLPEC_SYNC_FREEZE];
	// internal source is already on core_clk
	assign qual_s = sync_if.synced[`SLPEC_SYNC_QUAL] | qualify_int;

	// user writes only while running, idle and holding valid context
	assign user_wr_ok = ctx_we && st_r.fsm == SLPEC_RUN
		&& st_r.xfer == SLPEC_X_IDLE && st_r.ctx_valid
		&& core_pwr_good;

	always_comb
	begin
		st_nxt    = st_r;
		mem_we    = 1'b0;
		mem_waddr = ctx_addr;
		mem_wdata = ctx_wdata;

		// entry and exit
		unique case (st_r.fsm)
			SLPEC_RUN:
			begin
				if (freeze_s)
				begin
					st_nxt.fsm = entry_type2 ? SLPEC_WAIT_QUAL
						: SLPEC_FROZEN;
				end
			end
			SLPEC_WAIT_QUAL:
			begin
				// relies on user logic having quiesced first
				if (!freeze_s)
				begin
					st_nxt.fsm = SLPEC_RUN;
				end
				else if (qual_s)
				begin
					st_nxt.fsm = SLPEC_FROZEN;
				end
			end
			SLPEC_FROZEN:
			begin
				if (!freeze_s)
				begin
					st_nxt.fsm = SLPEC_RUN;
				end
			end
			default:
			begin
				st_nxt.fsm = SLPEC_RUN;
			end
		endcase

		st_nxt.frozen  = st_nxt.fsm == SLPEC_FROZEN;
		st_nxt.holdoff = st_nxt.fsm == SLPEC_WAIT_QUAL;
		// pads parked for the whole static state
		st_nxt.io_out = st_nxt.frozen ? SAFE_OUT : io_out_in;
		st_nxt.io_oe  = st_nxt.frozen ? SAFE_OE : io_oe_in;

		if (user_wr_ok)
		begin
			mem_we = 1'b1;
		end

		// context streams
		unique case (st_r.xfer)
			SLPEC_X_IDLE:
			begin
				if (restore_start)
				begin
					st_nxt.xfer      = SLPEC_X_RESTORE;
					st_nxt.cnt       = '0;
					st_nxt.ctx_valid = 1'b0;
					st_nxt.rs_done   = 1'b0;
				end
				else if (save_start && st_r.ctx_valid)
				begin
					st_nxt.xfer = SLPEC_X_SAVE;
					st_nxt.cnt  = '0;
				end
				else if (cold_start)
				begin
					st_nxt.ctx_valid = 1'b1;
				end
			end
			SLPEC_X_SAVE:
			begin
				if (!st_r.sv_valid || save_ready)
				begin
					if (st_r.sv_valid && st_r.sv_last)
					begin
						st_nxt.sv_valid = 1'b0;
						st_nxt.sv_last  = 1'b0;
						st_nxt.xfer     = SLPEC_X_IDLE;
					end
					else
					begin
						st_nxt.sv_valid = 1'b1;
						st_nxt.sv_data  = mem[st_r.cnt];
						st_nxt.sv_last  = st_r.cnt == AW'(DEPTH - 1);
						st_nxt.cnt      = st_r.cnt + 1'b1;
					end
				end
			end
			SLPEC_X_RESTORE:
			begin
				if (restore_valid)
				begin
					mem_we     = 1'b1;
					mem_waddr  = st_r.cnt;
					mem_wdata  = restore_data;
					st_nxt.cnt = st_r.cnt + 1'b1;
					if (st_r.cnt == AW'(DEPTH - 1))
					begin
						st_nxt.xfer      = SLPEC_X_IDLE;
						st_nxt.ctx_valid = 1'b1;
						st_nxt.rs_done   = 1'b1;
					end
				end
			end
			default:
			begin
				st_nxt.xfer = SLPEC_X_IDLE;
			end
		endcase

		st_nxt.rdata = st_r.ctx_valid ? mem[ctx_addr] : '0;

		// core power gone: stored context is no longer trusted
		if (!core_pwr_good)
		begin
			st_nxt.ctx_valid = 1'b0;
			st_nxt.xfer      = SLPEC_X_IDLE;
			st_nxt.sv_valid  = 1'b0;
			st_nxt.sv_last   = 1'b0;
			st_nxt.rs_done   = 1'b0;
			mem_we           = 1'b0;
		end

		if (srst)
		begin
			st_nxt        = '0;
			st_nxt.fsm    = SLPEC_RUN;
			st_nxt.xfer   = SLPEC_X_IDLE;
			st_nxt.io_out = SAFE_OUT;
			st_nxt.io_oe  = SAFE_OE;
			mem_we        = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		st_r <= st_nxt;
	end

	// no reset on storage: contents survive the static state
	always_ff @(posedge core_clk)
	begin
		if (mem_we)
		begin
			mem[mem_waddr] <= mem_wdata;
		end
	end

	assign frozen       = st_r.frozen;
	assign holdoff      = st_r.holdoff;
	assign state        = st_r.fsm;
	assign io_out       = st_r.io_out;
	assign io_oe        = st_r.io_oe;
	assign ctx_rdata    = st_r.rdata;
	assign ctx_valid    = st_r.ctx_valid;
	assign save_valid   = st_r.sv_valid;
	assign save_data    = st_r.sv_data;
	assign save_last    = st_r.sv_last;
	assign restore_done = st_r.rs_done;
endmodule // slpec_ctrl

// ### rtl/slpec_pkg.sv
/*
 * Types for the static low-power entry controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package slpec_pkg;

	typedef enum logic [1:0] {
		SLPEC_RUN       = 2'b00,
		SLPEC_WAIT_QUAL = 2'b01,
		SLPEC_FROZEN    = 2'b10
	} slpec_fsm_t;

	typedef enum logic [1:0] {
		SLPEC_X_IDLE    = 2'b00,
		SLPEC_X_SAVE    = 2'b01,
		SLPEC_X_RESTORE = 2'b10
	} slpec_xfer_t;

endpackage

// ### rtl/slpec_sync.sv
/*
 * Two-flop synchroniser for the freeze and qualify pins.
 * Assumes pins are asynchronous to core_clk.
 */
`timescale 1ns/1ps
`include "slpec_consts.svh"

module slpec_sync
(
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// pin levels in, synchronised levels out
	slpec_sync_if.sync port_if
);
	import slpec_pkg::*;

	typedef struct packed {
		logic [`SLPEC_SYNC_W-1:0] meta;
		logic [`SLPEC_SYNC_W-1:0] stable;
	} slpec_sync_st_t;

	slpec_sync_st_t st_r;
	slpec_sync_st_t st_nxt;

	// first stage feeds only the second
	always_comb
	begin
		st_nxt.meta   = port_if.raw;
		st_nxt.stable = st_r.meta;
		if (srst)
		begin
			st_nxt = '0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		st_r <= st_nxt;
	end

	assign port_if.synced = st_r.stable;
endmodule // slpec_sync

// ### rtl/slpec_sync_if.sv
/*
 * Interface carrying raw pin levels into the synchroniser and the
 * synchronised levels back out.
 * Assumes both ends share core_clk.
 */
`timescale 1ns/1ps
`include "slpec_consts.svh"

interface slpec_sync_if;
	logic [`SLPEC_SYNC_W-1:0] raw;
	logic [`SLPEC_SYNC_W-1:0] synced;

	modport sync
	(
		input  raw,
		output synced
	);

	modport user
	(
		output raw,
		input  synced
	);
endinterface

// ### verification/slpec_ctrl_checker.sv
/* slpec_ctrl_checker: port assertions bound into slpec_ctrl.
   assumes one clock, core_clk, and synchronous srst. */
`timescale 1ns/1ps
module slpec_ctrl_checker
#(
	parameter int              IO_W     = 8,
	parameter logic [IO_W-1:0] SAFE_OUT = 8'h00,
	parameter logic [IO_W-1:0] SAFE_OE  = 8'h00
)
(
	// clock and reset
	input wire logic            core_clk,
	input wire logic            srst,
	// entry control and status
	input wire logic            freeze_request_pin,
	input wire logic            qualify_pin,
	input wire logic            qualify_int,
	input wire logic            entry_type2,
	input wire logic            frozen,
	input wire logic            holdoff,
	// pads, power, context
	input wire logic [IO_W-1:0] io_out,
	input wire logic [IO_W-1:0] io_oe,
	input wire logic            core_pwr_good,
	input wire logic            ctx_valid,
	input wire logic            save_valid,
	input wire logic            restore_done
);
	import slpec_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	a_safe_pads: assert property (
		frozen |-> io_out == SAFE_OUT && io_oe == SAFE_OE)
		else $error("pads not safe while frozen");
	a_pin_alone: assert property (
		(!entry_type2 && !holdoff && freeze_request_pin
		&& core_pwr_good) [*3] |=> frozen)
		else $error("first variant did not freeze");
	a_qual_wait: assert property (
		holdoff && !qualify_int && !$past(qualify_pin, 2) |=> !frozen)
		else $error("froze without qualifier");
	a_qual_entry: assert property (
		holdoff && qualify_int && core_pwr_good
		&& $past(freeze_request_pin, 2) |=> frozen)
		else $error("qualified entry missed");
	// a raw pin edge must not reach the fsm before two flops
	a_sync_delay: assert property (
		$rose(frozen) |-> $past(freeze_request_pin, 3))
		else $error("freeze taken before sync");
	a_pwr_loss: assert property (
		!core_pwr_good |=> !ctx_valid && !save_valid)
		else $error("context kept over power loss");
	a_restore_ok: assert property (
		$rose(restore_done) |-> ctx_valid)
		else $error("restore done without valid context");
endmodule // slpec_ctrl_checker

bind slpec_ctrl slpec_ctrl_checker #(
	.IO_W(IO_W), .SAFE_OUT(SAFE_OUT), .SAFE_OE(SAFE_OE)
) chk (
	.core_clk, .srst, .freeze_request_pin, .qualify_pin, .qualify_int,
	.entry_type2, .frozen, .holdoff, .io_out, .io_oe, .core_pwr_good,
	.ctx_valid, .save_valid, .restore_done
);

// ### verification/slpec_mcu_model.sv
/* slpec_mcu_model: context controller with its own image store.
   assumes both streams run on core_clk. */
`timescale 1ns/1ps
module slpec_mcu_model
#(
	parameter int DATA_W = 8,
	parameter int DEPTH  = 16
)
(
	// clock and pacing
	input  wire logic              core_clk,
	input  wire logic              slow,
	// save stream
	input  wire logic              save_valid,
	input  wire logic [DATA_W-1:0] save_data,
	input  wire logic              save_last,
	output logic                   save_start,
	output logic                   save_ready,
	// restore stream
	output logic                   restore_start,
	output logic                   restore_valid,
	output logic [DATA_W-1:0]      restore_data
);
	logic [DATA_W-1:0] img [DEPTH];
	int                n_r;
	logic              tick_r;

	initial
	begin
		{save_start, restore_start, restore_valid, tick_r} = '0;
		n_r = 0;
		restore_data = '0;
	end
	// slow mode accepts a word only on every other cycle
	assign save_ready = tick_r || !slow;
	always @(posedge core_clk)
	begin
		tick_r <= !tick_r;
		if (save_valid && save_ready)
		begin
			img[n_r] <= save_data;
			n_r      <= save_last ? 0 : n_r + 1;
		end
	end
	task automatic save();
		@(posedge core_clk);
		save_start <= 1'b1;
		@(posedge core_clk);
		save_start <= 1'b0;
	endtask
	task automatic restore();
		@(posedge core_clk);
		restore_start <= 1'b1;
		for (int i = 0; i < DEPTH; i++)
		begin
			@(posedge core_clk);
			restore_start <= 1'b0;
			restore_valid <= 1'b1;
			restore_data  <= img[i];
		end
		@(posedge core_clk);
		restore_valid <= 1'b0;
		// idle data never repeats the last word
		restore_data  <= ~restore_data;
	endtask
endmodule // slpec_mcu_model

// ### verification/static_low_power_entry_ctrl_tb_top.sv
/* bench for slpec_ctrl: entry table, context, save, restore, reset.
   assumes the checker is bound and the model plays the controller. */
`timescale 1ns/1ps
module static_low_power_entry_ctrl_tb_top;
	import slpec_pkg::*;
	// control and status
	logic       core_clk, srst, freeze_request_pin, qualify_pin;
	logic       qualify_int, entry_type2, frozen, holdoff;
	slpec_fsm_t state;
	// pads and context
	logic [7:0] io_out_in, io_oe_in, io_out, io_oe, ctx_wdata, ctx_rdata;
	logic [3:0] ctx_addr;
	logic       ctx_we, ctx_valid, core_pwr_good, cold_start, slow;
	// streams
	logic       save_start, save_ready, save_valid, save_last;
	logic       restore_start, restore_valid, restore_done;
	logic [7:0] save_data, restore_data;
	int         mismatches, cmp_count;
	// type2, qual_int, qual_pin, frozen, holdoff
	logic [4:0] rows [5] = '{5'b00010, 5'b01010, 5'b10001, 5'b11010,
		5'b10110};

	slpec_ctrl uut (.*);
	slpec_mcu_model p (.*);

	always #2 core_clk = ~core_clk;

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		ctx_we    <= 1'b1;
		ctx_addr  <= a;
		ctx_wdata <= d;
		@(posedge core_clk);
		ctx_we    <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		ctx_addr <= a;
		repeat (2) @(posedge core_clk);
		chk(ctx_rdata, e);
	endtask
	task automatic results();
		$display("compares %0d bad %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		{core_clk, freeze_request_pin, qualify_pin, qualify_int} = '0;
		{entry_type2, ctx_we, cold_start, slow, ctx_addr} = '0;
		{srst, core_pwr_good, mismatches, cmp_count} = {2'b11, 64'd0};
		{io_out_in, io_oe_in, ctx_wdata} = {8'ha5, 8'h5a, 8'h00};
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		foreach (rows[i])
		begin
			@(posedge core_clk);
			// user side is idle here, so qualifying is always clean
			{entry_type2, qualify_int, qualify_pin} <= rows[i][4:2];
			freeze_request_pin <= 1'b1;
			repeat (6) @(posedge core_clk);
			chk(frozen, rows[i][1]);
			chk(holdoff, rows[i][0]);
			chk(io_out, rows[i][1] ? 8'h00 : 8'ha5);
			chk(io_oe, rows[i][1] ? 8'h00 : 8'h5a);
			{freeze_request_pin, qualify_int, qualify_pin} <= 3'b000;
			repeat (5) @(posedge core_clk);
			chk(state, SLPEC_RUN);
			$display("row %0d done", i);
		end
		// load context, then a write while frozen must bounce
		cold_start <= 1'b1;
		entry_type2 <= 1'b0;
		@(posedge core_clk);
		cold_start <= 1'b0;
		for (int i = 0; i < 16; i++)
			wr(i[3:0], 8'h30 + i[7:0]);
		freeze_request_pin <= 1'b1;
		repeat (4) @(posedge core_clk);
		wr(4'h3, 8'hee);
		freeze_request_pin <= 1'b0;
		repeat (5) @(posedge core_clk);
		rd(4'h3, 8'h33);
		$display("frozen write test done");
		slow <= 1'b1;
		p.save();
		repeat (100)
		begin
			@(posedge core_clk);
			if (save_valid && save_ready && save_last)
				break;
		end
		@(posedge core_clk);
		for (int i = 0; i < 16; i++)
			chk(p.img[i], 8'h30 + i[7:0]);
		core_pwr_good <= 1'b0;
		@(posedge core_clk);
		core_pwr_good <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk(ctx_valid, 1'b0);
		rd(4'h3, 8'h00);
		// nothing trusted to save after power loss
		p.save();
		repeat (2) @(posedge core_clk);
		chk(save_valid, 1'b0);
		p.restore();
		repeat (2) @(posedge core_clk);
		chk(restore_done, 1'b1);
		chk(ctx_valid, 1'b1);
		for (int i = 0; i < 16; i++)
			rd(i[3:0], 8'h30 + i[7:0]);
		$display("save and restore test done");
		// reset in mid-freeze
		freeze_request_pin <= 1'b1;
		repeat (5) @(posedge core_clk);
		srst <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(frozen, 1'b0);
		chk(ctx_valid, 1'b0);
		chk(io_out, 8'h00);
		// pin held over the release: sync restarts from zero
		srst <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk(frozen, 1'b1);
		chk(io_oe, 8'h00);
		freeze_request_pin <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk(state, SLPEC_RUN);
		chk(io_out, 8'ha5);
		$display("reset test done");
		results();
	end

	// whole run is well under 2000 cycles
	initial
	begin
		#40000;
		mismatches++;
		results();
	end
endmodule // static_low_power_entry_ctrl_tb_top
